// >>> design/rate_limit_pkg.sv
package rate_limit_pkg;

    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_PRIO      = 8'h04;
    localparam logic [7:0] ADDR_RATES     = 8'h08;
    localparam logic [7:0] ADDR_DT_CFG    = 8'h0C;
    localparam logic [7:0] ADDR_STK_CFG   = 8'h10;
    localparam logic [7:0] ADDR_OUT_CFG   = 8'h14;
    localparam logic [7:0] ADDR_DELAYS    = 8'h18;
    localparam logic [7:0] ADDR_STATUS    = 8'h1C;
    localparam logic [7:0] ADDR_RATE_OUT  = 8'h20;

    // -----------------------------------------------------------------
    // Control register fields
    // -----------------------------------------------------------------
    localparam int CTRL_DT_EN      = 0;
    localparam int CTRL_STK_EN     = 1;
    localparam int CTRL_SS_EN      = 2;
    localparam int CTRL_OUT_EN     = 3;
    localparam int CTRL_FR_EN      = 4;
    localparam int CTRL_AC_EN      = 5;
    localparam int CTRL_DT_LOCK    = 6;
    localparam int CTRL_STK_LOCK   = 7;
    localparam int CTRL_ALERT_CLR  = 8;

    // Reducer indices inside the priority vector.
    localparam int RED_DT  = 0;
    localparam int RED_STK = 1;
    localparam int RED_SS  = 2;
    localparam int RED_OUT = 3;
    localparam int RED_FR  = 4;
    localparam int NUM_RED = 5;

    // -----------------------------------------------------------------
    // Reset values and timing
    // -----------------------------------------------------------------
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [4:0]  PRIO_RESET  = 5'h00;
    localparam logic [7:0]  RATE_MAX_RESET = 8'hFF;
    localparam logic [7:0]  RATE_MIN_RESET = 8'h00;
    localparam logic [7:0]  THRESH_NONE = 8'h00;
    localparam int          STEP_ENTRY_DEG = 10;
    localparam int          STEP_PITCH_DEG = 2;
    localparam int          STEP_HYST_DEG  = 2;
    localparam int          NUM_STEPS      = 5;
    localparam int          CLOCK_HZ       = 50_000_000;
    localparam int          TICK_US        = 1000;
    localparam int          TICK_CYCLES    = CLOCK_HZ / 1_000_000 * TICK_US;

    // -----------------------------------------------------------------
    // Carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [NUM_RED-1:0] req;
        logic [7:0]         ss_rate;
        logic [7:0]         fr_rate;
        logic               ac_req;
        logic [7:0]         ac_rate;
    } limit_req_t;

    typedef struct packed {
        logic lockout;
        logic recycle;
        logic hold;
    } burner_resp_t;

endpackage : rate_limit_pkg

// >>> design/stepped_limit.sv
`timescale 1ns/1ps
module stepped_limit (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Enable, monitored distance, rate range and update strobe
    input  wire logic       enable,
    input  wire logic [8:0] margin,
    input  wire logic [7:0] rate_max,
    input  wire logic [7:0] rate_min,
    input  wire logic       update,
    // Result
    output logic [2:0]      step,
    output logic [7:0]      cap,
    output logic            active
);
    import rate_limit_pkg::*;

    logic [2:0] step_reg;
    logic [2:0] step_next;
    logic [2:0] entry_step;
    logic [8:0] exit_bound;
    logic [7:0] stepsize;
    logic [10:0] cut;

    // Entry step for a distance: 10 deg gives step 1, each 2 deg closer adds one.
    assign entry_step = (margin > 9'(STEP_ENTRY_DEG)) ? 3'd0 :
                        (margin <= 9'(STEP_PITCH_DEG)) ? 3'(NUM_STEPS) :
                        3'(1 + (STEP_ENTRY_DEG - int'(margin)) / STEP_PITCH_DEG);
    // Leaving the present step needs the distance to pass its entry bound plus hysteresis.
    assign exit_bound = 9'(STEP_ENTRY_DEG + STEP_HYST_DEG
                        - (int'(step_reg) - 1) * STEP_PITCH_DEG);

    always_comb begin
        step_next = step_reg;
        if (!enable) begin
            step_next = 3'd0;
        end else if (entry_step > step_reg) begin
            step_next = entry_step;
        end else if (step_reg != 3'd0 && margin > exit_bound) begin
            step_next = step_reg - 3'd1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            step_reg <= 3'd0;
        end else if (update) begin
            step_reg <= step_next;
        end
    end

    // The cap steps down one fifth of the range per step, ending at minimum.
    assign stepsize = (rate_max - rate_min) / 8'(NUM_STEPS);
    assign cut      = 11'(stepsize) * 11'(step_reg);
    assign cap      = (step_reg == 3'(NUM_STEPS)) ? rate_min : 8'(rate_max - cut[7:0]);
    assign step     = step_reg;
    assign active   = step_reg != 3'd0;

endmodule : stepped_limit

// >>> design/firing_rate_limit_arbiter.sv
// What this block does
// - Delta, stack, slow start, outlet and forced rate are all reducers.
// - One priority setting gives anticondensation precedence per reducer.
// - A limit is active only when enabled and requesting.
// - Anticondensation alone active sets the firing rate.
// - Otherwise the lowest rate among active reducers outranking anticondensation wins.
// - Anticondensation outranking every active reducer sets the rate.
// - Without anticondensation the lowest active reducer rate wins.
// - Alert for delta, stack, outlet, anticondensation limits; not slow start, forced.
// - Delta enable switches both its rate limit and its burner response.
// - Delta trips when outlet exceeds inlet by more than a nonzero threshold.
// - Stepped limiting caps the rate as delta nears its threshold.
// - Delta trip locks out, or recycles with alert, holds delay, retries.
// - Stack enable switches both its safety response and rate limit.
// - Stack trips when stack temperature reaches or exceeds its setpoint.
// - Stepped limiting caps the rate as stack nears its setpoint.
// - Steps of one fifth range from 10 deg, every 2 deg, to minimum.
// - Returning to a looser step needs 2 deg extra distance.
`timescale 1ns/1ps
module firing_rate_limit_arbiter #(
    parameter int TICK_COUNT = rate_limit_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst,
    // Register port
    input  wire logic [7:0]                 addr,
    input  wire logic [31:0]                wdata,
    input  wire logic                       wr_en,
    input  wire logic                       rd_en,
    output logic [31:0]                     rdata,
    // Temperatures and demand
    input  wire logic [7:0]                 inlet_temp,
    input  wire logic [7:0]                 outlet_temp,
    input  wire logic [7:0]                 stack_temp,
    input  wire logic [8:0]                 outlet_margin,
    input  wire logic [7:0]                 demand_rate,
    input  wire logic                       demand,
    input  wire rate_limit_pkg::limit_req_t limits,
    // Sequencer side
    output rate_limit_pkg::burner_resp_t    response,
    output logic [7:0]                      firing_rate,
    output logic                            alert
);
    import rate_limit_pkg::*;

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [4:0]  prio_reg;
    logic [7:0]  rmax_reg;
    logic [7:0]  rmin_reg;
    logic [7:0]  dt_thr_reg;
    logic [7:0]  stk_set_reg;
    logic [15:0] dt_delay_reg;
    logic [15:0] stk_delay_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [7:0]  rate_reg;
    logic [7:0]  rate_next;
    logic        alert_reg;
    logic        alert_next;
    logic [31:0] tick_cnt_reg;
    logic        tick;

    // -----------------------------------------------------------------
    // Register decode
    // -----------------------------------------------------------------
    wire w_ctrl  = wr_en && addr == ADDR_CTRL;
    wire w_prio  = wr_en && addr == ADDR_PRIO;
    wire w_rates = wr_en && addr == ADDR_RATES;
    wire w_dt    = wr_en && addr == ADDR_DT_CFG;
    wire w_stk   = wr_en && addr == ADDR_STK_CFG;
    wire w_dly   = wr_en && addr == ADDR_DELAYS;
    wire alert_clr = w_ctrl && wdata[CTRL_ALERT_CLR];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_reg      <= CTRL_RESET;
            prio_reg      <= PRIO_RESET;
            rmax_reg      <= RATE_MAX_RESET;
            rmin_reg      <= RATE_MIN_RESET;
            dt_thr_reg    <= THRESH_NONE;
            stk_set_reg   <= THRESH_NONE;
            dt_delay_reg  <= 16'h0000;
            stk_delay_reg <= 16'h0000;
        end else begin
            if (w_ctrl) ctrl_reg <= {24'h000000, wdata[7:0]};
            if (w_prio) prio_reg <= wdata[4:0];
            if (w_rates) begin
                rmin_reg <= wdata[7:0];
                rmax_reg <= wdata[15:8];
            end
            if (w_dt) dt_thr_reg <= wdata[7:0];
            if (w_stk) stk_set_reg <= wdata[7:0];
            if (w_dly) begin
                dt_delay_reg  <= wdata[15:0];
                stk_delay_reg <= wdata[31:16];
            end
        end
    end

    // -----------------------------------------------------------------
    // Control update tick
    // -----------------------------------------------------------------
    assign tick = tick_cnt_reg == 32'(TICK_COUNT - 1);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else begin
            tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
        end
    end

    // -----------------------------------------------------------------
    // Delta, stack and outlet limit evaluation
    // -----------------------------------------------------------------
    wire       dt_en   = ctrl_reg[CTRL_DT_EN];
    wire       stk_en  = ctrl_reg[CTRL_STK_EN];
    wire       out_hot = outlet_temp > inlet_temp;
    wire [7:0] dt_diff = out_hot ? outlet_temp - inlet_temp : 8'h00;
    // An unset threshold never trips and keeps the delta stepped limit switched off.
    wire       dt_trip = dt_en && out_hot && dt_thr_reg != THRESH_NONE
                         && dt_diff > dt_thr_reg;
    wire       stk_trip = stk_en && stk_set_reg != THRESH_NONE
                          && stack_temp >= stk_set_reg;
    wire [8:0] dt_margin  = (dt_diff >= dt_thr_reg) ? 9'h000 : 9'(dt_thr_reg - dt_diff);
    wire [8:0] stk_margin = (stack_temp >= stk_set_reg) ? 9'h000
                            : 9'(stk_set_reg - stack_temp);

    logic [7:0] dt_cap;
    logic [7:0] stk_cap;
    logic [7:0] out_cap;
    logic       dt_lim;
    logic       stk_lim;
    logic       out_lim;

    stepped_limit u_dt_step (
        .clock    (clock),
        .rst      (rst),
        .enable   (dt_en && dt_thr_reg != THRESH_NONE),
        .margin   (dt_margin),
        .rate_max (rmax_reg),
        .rate_min (rmin_reg),
        .update   (tick),
        .step     (),
        .cap      (dt_cap),
        .active   (dt_lim)
    );

    stepped_limit u_stk_step (
        .clock    (clock),
        .rst      (rst),
        .enable   (stk_en && stk_set_reg != THRESH_NONE),
        .margin   (stk_margin),
        .rate_max (rmax_reg),
        .rate_min (rmin_reg),
        .update   (tick),
        .step     (),
        .cap      (stk_cap),
        .active   (stk_lim)
    );

    stepped_limit u_out_step (
        .clock    (clock),
        .rst      (rst),
        .enable   (ctrl_reg[CTRL_OUT_EN]),
        .margin   (outlet_margin),
        .rate_max (rmax_reg),
        .rate_min (rmin_reg),
        .update   (tick),
        .step     (),
        .cap      (out_cap),
        .active   (out_lim)
    );

    // -----------------------------------------------------------------
    // Burner responses
    // -----------------------------------------------------------------
    logic [15:0] dt_hold_reg;
    logic [15:0] stk_hold_reg;
    logic        lock_reg;
    logic        recycle_reg;

    wire dt_lockout  = dt_trip && ctrl_reg[CTRL_DT_LOCK];
    wire stk_lockout = stk_trip && ctrl_reg[CTRL_STK_LOCK];
    wire dt_recycle  = dt_trip && !ctrl_reg[CTRL_DT_LOCK] && dt_hold_reg == 16'h0000;
    wire stk_recycle = stk_trip && !ctrl_reg[CTRL_STK_LOCK] && stk_hold_reg == 16'h0000;

    // Lockout is latched until reset; the sequencer must not clear it silently.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lock_reg     <= 1'b0;
            recycle_reg  <= 1'b0;
            dt_hold_reg  <= 16'h0000;
            stk_hold_reg <= 16'h0000;
        end else begin
            lock_reg    <= lock_reg || dt_lockout || stk_lockout;
            recycle_reg <= dt_recycle || stk_recycle;
            if (dt_recycle) begin
                dt_hold_reg <= dt_delay_reg | 16'h0001;
            end else if (tick && dt_hold_reg != 16'h0000) begin
                dt_hold_reg <= dt_hold_reg - 16'h0001;
            end
            if (stk_recycle) begin
                stk_hold_reg <= stk_delay_reg | 16'h0001;
            end else if (tick && stk_hold_reg != 16'h0000) begin
                stk_hold_reg <= stk_hold_reg - 16'h0001;
            end
        end
    end

    // Retry happens when hold drops while demand remains.
    assign response.lockout = lock_reg;
    assign response.recycle = recycle_reg;
    assign response.hold    = (dt_hold_reg != 16'h0000 || stk_hold_reg != 16'h0000)
                              && demand;

    // -----------------------------------------------------------------
    // Arbitration
    // -----------------------------------------------------------------
    logic [NUM_RED-1:0] red_act;
    logic [7:0]         red_rate [NUM_RED];

    assign red_act[RED_DT]  = dt_lim;
    assign red_act[RED_STK] = stk_lim;
    assign red_act[RED_SS]  = ctrl_reg[CTRL_SS_EN] && limits.req[RED_SS];
    assign red_act[RED_OUT] = out_lim;
    assign red_act[RED_FR]  = ctrl_reg[CTRL_FR_EN] && limits.req[RED_FR];
    assign red_rate[RED_DT]  = dt_cap;
    assign red_rate[RED_STK] = stk_cap;
    assign red_rate[RED_SS]  = limits.ss_rate;
    assign red_rate[RED_OUT] = out_cap;
    assign red_rate[RED_FR]  = limits.fr_rate;

    wire ac_act = ctrl_reg[CTRL_AC_EN] && limits.ac_req;
    // Reducers that beat anticondensation; all of them when it is idle.
    wire [NUM_RED-1:0] winners = ac_act ? (red_act & ~prio_reg) : red_act;

    always_comb begin
        rate_next = demand_rate;
        if (winners != '0) begin
            rate_next = 8'hFF;
            for (int i = 0; i < NUM_RED; i++) begin
                if (winners[i] && red_rate[i] < rate_next) begin
                    rate_next = red_rate[i];
                end
            end
            // A winning forced rate drops the demand cap for every winner; otherwise caps only lower it.
            if (!winners[RED_FR] && demand_rate < rate_next) begin
                rate_next = demand_rate;
            end
        end else if (ac_act) begin
            rate_next = limits.ac_rate;
        end
    end

    wire ac_effect = ac_act && winners == '0;
    assign alert_next = (alert_reg && !alert_clr) || dt_lim || stk_lim || out_lim
                        || ac_effect || dt_recycle;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rate_reg  <= 8'h00;
            alert_reg <= 1'b0;
        end else if (tick) begin
            rate_reg  <= rate_next;
            alert_reg <= alert_next;
        end else begin
            alert_reg <= (alert_reg && !alert_clr) || dt_recycle;
        end
    end

    assign firing_rate = rate_reg;
    assign alert       = alert_reg;

    // -----------------------------------------------------------------
    // Read path
    // -----------------------------------------------------------------
    wire [31:0] status_word = {16'h0000, 3'b000, ac_act, red_act, lock_reg,
                               stk_trip, dt_trip, alert_reg, stk_hold_reg != 16'h0000,
                               dt_hold_reg != 16'h0000, recycle_reg};

    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (addr)
            ADDR_CTRL:     rdata_next = ctrl_reg;
            ADDR_PRIO:     rdata_next = {27'h0000000, prio_reg};
            ADDR_RATES:    rdata_next = {16'h0000, rmax_reg, rmin_reg};
            ADDR_DT_CFG:   rdata_next = {24'h000000, dt_thr_reg};
            ADDR_STK_CFG:  rdata_next = {24'h000000, stk_set_reg};
            ADDR_DELAYS:   rdata_next = {stk_delay_reg, dt_delay_reg};
            ADDR_STATUS:   rdata_next = status_word;
            ADDR_RATE_OUT: rdata_next = {24'h000000, rate_reg};
            default:       rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rd_en ? rdata_next : 32'h0000_0000;
        end
    end

    assign rdata = rdata_reg;

endmodule : firing_rate_limit_arbiter

// >>> verification/rate_arbiter_checker.sv
`timescale 1ns/1ps
module rate_arbiter_checker
    import rate_limit_pkg::*;
#(
    parameter int TICK_COUNT = 4
) (
    // Clock and reset
    input wire logic                       clock,
    input wire logic                       rst,
    // Register port
    input wire logic [7:0]                 addr,
    input wire logic [31:0]                wdata,
    input wire logic                       wr_en,
    input wire logic                       rd_en,
    input wire logic [31:0]                rdata,
    // Demand and sequencer side
    input wire logic [7:0]                 demand_rate,
    input wire logic                       demand,
    input wire rate_limit_pkg::limit_req_t limits,
    input wire rate_limit_pkg::burner_resp_t response,
    input wire logic [7:0]                 firing_rate,
    input wire logic                       alert
);
    logic [15:0] gap;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Cycles since the firing rate last moved; zero until it has moved once.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gap <= 16'h0000;
        end else if ($changed(firing_rate)) begin
            gap <= 16'h0001;
        end else if (gap != 16'h0000 && gap != 16'hFFFF) begin
            gap <= gap + 16'h0001;
        end
    end

    a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    a_rdata_unmapped: assert property (rd_en && (addr > ADDR_RATE_OUT || addr[1:0] != 2'h0)
        |=> rdata == 32'h0) else $error("unmapped read returned data");
    a_rate_on_tick: assert property ($changed(firing_rate) && gap != 16'h0000 |->
        gap >= TICK_COUNT) else $error("firing rate moved between ticks");
    a_rate_demand_cap: assert property ($changed(firing_rate) |->
        firing_rate <= $past(demand_rate) || $past(limits.req[RED_FR]) || $past(limits.ac_req))
        else $error("firing rate above demand");
    a_alert_sticky: assert property (alert && !(wr_en && addr == ADDR_CTRL
        && wdata[CTRL_ALERT_CLR]) |=> alert) else $error("alert dropped without clear");
    a_recycle_pulse: assert property (response.recycle |=> !response.recycle)
        else $error("recycle longer than one cycle");
    a_lockout_latch: assert property (response.lockout |=> response.lockout)
        else $error("lockout released before reset");
    a_hold_needs_demand: assert property (!demand [*2] |-> !response.hold)
        else $error("hold without demand");

    c_lockout: cover property (response.lockout);
    c_recycle: cover property (response.recycle);
    c_alert_clear: cover property ($fell(alert));
    c_ac_rate: cover property (limits.ac_req && firing_rate == limits.ac_rate);
endmodule : rate_arbiter_checker

bind firing_rate_limit_arbiter rate_arbiter_checker #(.TICK_COUNT(TICK_COUNT)) chk_u (
    .clock, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .demand_rate, .demand,
    .limits, .response, .firing_rate, .alert
);

// >>> verification/burner_side_model.sv
`timescale 1ns/1ps
module burner_side_model
    import rate_limit_pkg::*;
(
    // Clock and reset
    input wire logic                         clock,
    input wire logic                         rst,
    // Sequencer inputs
    input wire rate_limit_pkg::burner_resp_t response,
    // Demand logic outputs
    output logic [7:0]                       demand_rate = 8'h00,
    output logic                             demand = 1'b0,
    output rate_limit_pkg::limit_req_t       limits = '0,
    // Observation
    output int                               recycle_count,
    output logic                             hold_seen
);
    // The sequencer only notes responses; recycles are counted so a burst is not missed.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            recycle_count <= 0;
            hold_seen <= 1'b0;
        end else begin
            if (response.recycle === 1'b1) recycle_count <= recycle_count + 1;
            if (response.hold === 1'b1) hold_seen <= 1'b1;
        end
    end

    task automatic set_demand(input logic [7:0] r, input logic on);
        @(posedge clock);
        demand_rate <= r;
        demand <= on;
    endtask : set_demand

    task automatic set_lim(input logic [4:0] q, input logic [7:0] ss, input logic [7:0] fr,
                           input logic ac, input logic [7:0] acr);
        @(posedge clock);
        limits <= '{req: q, ss_rate: ss, fr_rate: fr, ac_req: ac, ac_rate: acr};
    endtask : set_lim
endmodule : burner_side_model

// >>> verification/firing_rate_limit_arbiter_tb.sv
`timescale 1ns/1ps
module firing_rate_limit_arbiter_tb;
    import rate_limit_pkg::*;
    localparam int TICKS = 4;
    logic         clock, rst, wr_en, rd_en, demand, alert, hold_seen;
    logic [7:0]   addr, inlet_temp, outlet_temp, stack_temp, demand_rate, firing_rate;
    logic [8:0]   outlet_margin;
    logic [31:0]  wdata, rdata;
    limit_req_t   limits;
    burner_resp_t response;
    int           recycle_count, err_count, samples_checked;

    firing_rate_limit_arbiter #(.TICK_COUNT(TICKS)) dut_u (.clock(clock), .rst(rst),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .inlet_temp(inlet_temp), .outlet_temp(outlet_temp), .stack_temp(stack_temp),
        .outlet_margin(outlet_margin), .demand_rate(demand_rate), .demand(demand),
        .limits(limits), .response(response), .firing_rate(firing_rate), .alert(alert));
    burner_side_model model_u (.clock(clock), .rst(rst), .response(response),
        .demand_rate(demand_rate), .demand(demand), .limits(limits),
        .recycle_count(recycle_count), .hold_seen(hold_seen));

    // ---------------------------------------------------------------
    // Access and compare tasks
    // ---------------------------------------------------------------
    task automatic report(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : report
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : reg_write
    task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        report(rdata, exp);
    endtask : reg_check
    task automatic temps(input logic [7:0] i, input logic [7:0] o, input logic [7:0] s,
                         input logic [8:0] m);
        @(posedge clock);
        inlet_temp <= i;
        outlet_temp <= o;
        stack_temp <= s;
        outlet_margin <= m;
    endtask : temps
    // Waits whole ticks, since the rate only moves on a control tick.
    task automatic settle(input int n);
        repeat (n * TICKS) @(posedge clock);
        #1;
    endtask : settle
    task automatic rate_check(input logic [7:0] exp);
        report({24'h0, firing_rate}, {24'h0, exp});
    endtask : rate_check
    task automatic flag_check(input logic got, input logic exp);
        report({31'h0, got}, {31'h0, exp});
    endtask : flag_check
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        err_count++;
        complete_run();
    end

    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        {rst, wr_en, rd_en, addr, wdata} = {1'b1, 42'h0};
        {inlet_temp, outlet_temp, stack_temp, outlet_margin} = {24'h404000, 9'h1FF};
        {err_count, samples_checked} = 0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        reg_check(ADDR_CTRL, 32'h0);
        reg_check(ADDR_RATES, 32'h0000FF00);
        reg_check(8'h24, 32'h0);
        rate_check(8'h00);
        model_u.set_demand(8'h80, 1'b1);
        settle(3);
        rate_check(8'h80);
        model_u.set_lim(5'h14, 8'h40, 8'h30, 1'b0, 8'h00);
        settle(3);
        rate_check(8'h80);
        reg_write(ADDR_CTRL, 32'h14);
        settle(3);
        rate_check(8'h30);
        model_u.set_lim(5'h14, 8'h40, 8'h50, 1'b0, 8'h00);
        settle(3);
        rate_check(8'h40);
        flag_check(alert, 1'b0);
        model_u.set_lim(5'h00, 8'h40, 8'h00, 1'b1, 8'h90);
        reg_write(ADDR_CTRL, 32'h24);
        settle(3);
        rate_check(8'h90);
        flag_check(alert, 1'b1);
        model_u.set_lim(5'h04, 8'h40, 8'h00, 1'b1, 8'h90);
        settle(3);
        rate_check(8'h40);
        reg_write(ADDR_PRIO, 32'h04);
        settle(3);
        rate_check(8'h90);
        reg_write(ADDR_PRIO, 32'h1B);
        settle(3);
        rate_check(8'h40);
        model_u.set_lim(5'h00, 8'h00, 8'h00, 1'b0, 8'h00);
        model_u.set_demand(8'hFF, 1'b1);
        reg_write(ADDR_CTRL, 32'h108);
        settle(3);
        flag_check(alert, 1'b0);
        rate_check(8'hFF);
        temps(8'h40, 8'h40, 8'h00, 9'h00A);
        settle(3);
        rate_check(8'hCC);
        flag_check(alert, 1'b1);
        temps(8'h40, 8'h40, 8'h00, 9'h002);
        settle(8);
        rate_check(8'h00);
        temps(8'h40, 8'h40, 8'h00, 9'h004);
        settle(3);
        rate_check(8'h00);
        temps(8'h40, 8'h40, 8'h00, 9'h005);
        settle(3);
        rate_check(8'h33);
        temps(8'h40, 8'h4B, 8'h00, 9'h1FF);
        reg_write(ADDR_DT_CFG, 32'h0A);
        reg_write(ADDR_DELAYS, 32'h00020002);
        settle(8);
        reg_write(ADDR_CTRL, 32'h100);
        settle(1);
        rate_check(8'hFF);
        flag_check(recycle_count != 0, 1'b0);
        flag_check(alert, 1'b0);
        temps(8'h40, 8'h40, 8'h00, 9'h1FF);
        reg_write(ADDR_CTRL, 32'h01);
        settle(3);
        rate_check(8'hCC);
        temps(8'h40, 8'h4A, 8'h00, 9'h1FF);
        model_u.set_lim(5'h00, 8'h00, 8'h00, 1'b0, 8'h00);
        settle(3);
        flag_check(recycle_count != 0, 1'b0);
        temps(8'h40, 8'h4B, 8'h00, 9'h1FF);
        settle(4);
        flag_check(recycle_count != 0, 1'b1);
        flag_check(hold_seen, 1'b1);
        flag_check(response.lockout, 1'b0);
        flag_check(alert, 1'b1);
        model_u.set_demand(8'hFF, 1'b0);
        settle(1);
        flag_check(response.hold, 1'b0);
        temps(8'h40, 8'h40, 8'h76, 9'h1FF);
        model_u.set_demand(8'hFF, 1'b1);
        reg_write(ADDR_STK_CFG, 32'h80);
        reg_write(ADDR_CTRL, 32'h82);
        settle(3);
        rate_check(8'hCC);
        flag_check(response.lockout, 1'b0);
        temps(8'h40, 8'h40, 8'h80, 9'h1FF);
        settle(3);
        flag_check(response.lockout, 1'b1);
        reg_check(ADDR_STATUS, 32'h00000168);
        reg_check(ADDR_RATE_OUT, 32'h00000000);
        @(posedge clock) rst <= 1'b1;
        @(posedge clock) rst <= 1'b0;
        settle(1);
        flag_check(response.lockout, 1'b0);
        complete_run();
    end
endmodule : firing_rate_limit_arbiter_tb
